// ===== src/difd_pkg.sv
`default_nettype none
package difd_pkg;
  // word geometry
  localparam int unsigned WORD_W = 24;
  localparam int unsigned REG_W = 16;
  localparam int unsigned RADDR_W = 4;
  // control group opcodes, full byte
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_BRANCH_ALWAYS = 8'h01;
  localparam logic [7:0] OPC_CALL_LONG = 8'h02;
  localparam logic [7:0] OPC_GOTO_LONG = 8'h04;
  localparam logic [7:0] OPC_LOOP_LONG = 8'h05;
  localparam logic [7:0] OPC_RETURN = 8'h06;
  localparam logic [7:0] OPC_RETURN_FROM_IRQ = 8'h07;
  localparam logic [7:0] OPC_CALL_IND = 8'h08;
  localparam logic [7:0] OPC_GOTO_IND = 8'h09;
  localparam logic [7:0] OPC_TABLE_RD = 8'h0A;
  localparam logic [7:0] OPC_TABLE_WR = 8'h0B;
  localparam logic [7:0] OPC_SKIP = 8'h0C;
  localparam logic [7:0] OPC_BRANCH_COND = 8'h0D;
  // opcode groups, upper nibble
  localparam logic [3:0] GRP_CTRL = 4'h0;
  localparam logic [3:0] GRP_DEFAULT_WORK_REG_LO = 4'h1;
  localparam logic [3:0] GRP_DEFAULT_WORK_REG_HI = 4'h5;
  localparam logic [3:0] GRP_FILE_LO = 4'h6;
  localparam logic [3:0] GRP_FILE_HI = 4'h7;
  localparam logic [3:0] GRP_BIT_LO = 4'h8;
  localparam logic [3:0] GRP_BIT_HI = 4'h9;
  localparam logic [3:0] GRP_LIT_LO = 4'hA;
  localparam logic [3:0] GRP_LIT_HI = 4'hB;
  localparam logic [3:0] GRP_MAC = 4'hC;
  localparam logic [3:0] GRP_DSP = 4'hD;
  localparam logic [3:0] GRP_DMOVE = 4'hE;
  // cycle totals per instruction kind
  localparam logic [1:0] CYC_FLOW = 2'h2;
  localparam logic [1:0] CYC_RETURN = 2'h3;
  localparam logic [1:0] CYC_COND = 2'h2;
  localparam logic [1:0] CYC_DMOVE = 2'h2;
  // operand limits and fixed registers
  localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
  localparam logic [3:0] DEFAULT_WORK_REG = 4'h0;
  localparam logic [3:0] MUL_BASE_REG = 4'h4;
  localparam logic [3:0] XPF_REG_LO = 4'h8;
  localparam logic [3:0] XPF_REG_HI = 4'h9;
  localparam logic [3:0] XPF_GROUP = 4'h7;
  localparam logic [3:0] XPF_CODE_OFS = 4'hE;
  localparam logic [3:0] XPF_CODE_NONE = 4'hF;
  localparam logic [1:0] AWB_CODE_REG = 2'h1;
  localparam logic [1:0] AWB_CODE_INC = 2'h2;
  localparam logic [3:0] AWB_REG = 4'hD;
  // flag update masks: C,DC,N,OV,Z,OA,OB,SA,SB from bit 0
  localparam logic [8:0] FLAGS_MCU = 9'h01F;
  localparam logic [8:0] FLAGS_ZERO = 9'h010;
  localparam logic [8:0] FLAGS_DSP = 9'h1E0;
  // register map and reset values
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_LAST = 4'h3;
  localparam logic [15:0] CTRL_RST = 16'h0001;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned STAT_ILL_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  // enumerations
  typedef enum logic [2:0] {CAT_WORD, CAT_BIT, CAT_LIT, CAT_DSP, CAT_CTRL} difd_cat_e;
  typedef enum logic [1:0] {WID_WORD, WID_BYTE, WID_DOUBLE} difd_width_e;
  // operand layouts of the low 16 bits
  typedef struct packed {
    logic [3:0] base; logic [2:0] dMode; logic [3:0] dReg; logic [3:0] sReg; logic pad;
  } difd_default_work_reg_s;
  typedef struct packed {logic [1:0] pad; logic toFile; logic [12:0] addr;} difd_file_s;
  typedef struct packed {
    logic [3:0] bitSel; logic [3:0] base; logic pad; logic [2:0] sMode; logic [3:0] sReg;
  } difd_bit_s;
  typedef struct packed {logic [9:0] lit; logic [1:0] pad; logic [3:0] base;} difd_lit_s;
  typedef struct packed {
    logic [4:0] lit; logic [2:0] dMode; logic [3:0] dReg; logic [3:0] base;
  } difd_lit5_s;
  typedef struct packed {
    logic [3:0] xPf; logic [1:0] xDst; logic [3:0] yPf; logic [1:0] yDst;
    logic [1:0] pad; logic [1:0] acc_writeback_target;
  } difd_mac_s;
  typedef struct packed {
    logic [5:0] shLit; logic [1:0] pad; logic toDst; logic [2:0] mode; logic [3:0] reg4;
  } difd_dsp_s;
  // decoded instruction
  typedef struct packed {
    logic [7:0]  opc;
    difd_cat_e   cat;
    difd_width_e width;
    logic        twoWord;
    logic [3:0]  baseWorkReg;
    logic [3:0]  sourceWorkReg;
    logic [2:0]  srcMode;
    logic [3:0]  destWorkReg;
    logic [2:0]  dstMode;
    logic [12:0] fileAddr;
    logic        toDefaultWorkReg;
    logic [3:0]  bitSelectField;
    logic        bitIndirect;
    logic [15:0] lit;
    logic        accB;
    logic [3:0]  mulM;
    logic [3:0]  mulN;
    logic        xPfEn;
    logic [3:0]  xPrefetchAddrReg;
    logic [3:0]  xPfStep;
    logic        xPfOfs;
    logic [1:0]  xDst;
    logic [3:0]  yPf;
    logic [1:0]  yDst;
    logic        awbEn;
    logic        awbPostInc;
    logic        shiftFromReg;
    logic [3:0]  shiftCountReg;
    logic [22:0] programAddrLiteral;
    logic [8:0]  flagMask;
    logic        illegal;
  } difd_dec_s;
endpackage
`default_nettype wire

// ===== src/difd_decoder.sv
`default_nettype none
module difd_decoder (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // fetch path
  input  wire logic                      fetchValid,
  input  wire logic [23:0]               fetchWord,
  output logic                           fetchReady,
  // datapath test result for the offered word
  input  wire logic                      condTrue,
  // decode result
  output logic                           decValid,
  output difd_pkg::difd_dec_s            decOut,
  output logic                           writeEnable,
  output logic                           nopCycle,
  // register port
  input  wire logic [3:0]                regAddr,
  input  wire logic [15:0]               regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic [15:0]                    regRdata
);

  typedef enum logic [2:0] {S_RUN, S_WORD2, S_WAIT, S_SKIP1, S_SKIP2} difd_state_e;

  difd_state_e         stateReg, stateNext;
  logic [23:0]         firstReg, firstNext;
  logic [1:0]          waitReg, waitNext;
  logic                waitNopReg, waitNopNext;
  difd_pkg::difd_dec_s decReg, decNext, dIssue;
  logic                decValidReg, decValidNext;
  logic                wrEnReg, wrEnNext;
  logic                nopReg, nopNext;
  logic                issue, take;
  logic [7:0]          opNow;
  logic [1:0]          extra;
  logic [15:0]         ctrlReg, ctrlNext;
  logic                illReg, illNext;
  logic [15:0]         countReg, countNext;
  logic [15:0]         rdataReg, rdataNext;

  // two-word opcodes: exactly three of them
  function automatic logic twoWordOp(input logic [7:0] op);
    twoWordOp = (op == difd_pkg::OPC_CALL_LONG) || (op == difd_pkg::OPC_GOTO_LONG)
             || (op == difd_pkg::OPC_LOOP_LONG);
  endfunction

  // cycles beyond the first one
  function automatic logic [1:0] extraCycles(input logic [7:0] op, input logic cond);
    logic [1:0] e;
    e = 2'h0;
    if (op[7:4] == difd_pkg::GRP_DMOVE) begin
      e = difd_pkg::CYC_DMOVE - 2'h1;
    end else begin
      case (op)
        difd_pkg::OPC_BRANCH_ALWAYS, difd_pkg::OPC_CALL_IND, difd_pkg::OPC_GOTO_IND,
        difd_pkg::OPC_TABLE_RD, difd_pkg::OPC_TABLE_WR: e = difd_pkg::CYC_FLOW - 2'h1;
        difd_pkg::OPC_RETURN, difd_pkg::OPC_RETURN_FROM_IRQ: e = difd_pkg::CYC_RETURN - 2'h1;
        difd_pkg::OPC_BRANCH_COND: e = cond ? difd_pkg::CYC_COND - 2'h1 : 2'h0;
        default: e = 2'h0;
      endcase
    end
    extraCycles = e;
  endfunction

  // splits a first word, and the second word where there is one, into fields
  function automatic difd_pkg::difd_dec_s decode(input logic [23:0] w1, input logic [23:0] w2);
    difd_pkg::difd_dec_s d;
    logic [7:0]          op;
    logic [15:0]         o;
    difd_pkg::difd_default_work_reg_s wr;
    difd_pkg::difd_file_s fr;
    difd_pkg::difd_bit_s  br;
    difd_pkg::difd_lit_s  lr;
    difd_pkg::difd_lit5_s l5;
    difd_pkg::difd_mac_s  mr;
    difd_pkg::difd_dsp_s  dr;
    logic [3:0]          k;
    d = '0;
    op = w1[23:16];
    o = w1[15:0];
    wr = o;
    fr = o;
    br = o;
    lr = o;
    l5 = o;
    mr = o;
    dr = o;
    d.opc = op;
    d.cat = difd_pkg::CAT_CTRL;
    d.width = op[3] ? difd_pkg::WID_BYTE : difd_pkg::WID_WORD;
    case (op[7:4]) inside
      [difd_pkg::GRP_DEFAULT_WORK_REG_LO:difd_pkg::GRP_DEFAULT_WORK_REG_HI], difd_pkg::GRP_DMOVE: begin
        d.cat = difd_pkg::CAT_WORD;
        d.baseWorkReg = wr.base;
        d.sourceWorkReg = wr.sReg;
        d.srcMode = op[2:0];
        d.destWorkReg = wr.dReg;
        d.dstMode = wr.dMode;
        d.flagMask = difd_pkg::FLAGS_MCU;
        if (op[7:4] == difd_pkg::GRP_DMOVE) begin
          d.width = difd_pkg::WID_DOUBLE;
          d.flagMask = '0;
        end
      end
      [difd_pkg::GRP_FILE_LO:difd_pkg::GRP_FILE_HI]: begin
        d.cat = difd_pkg::CAT_WORD;
        d.fileAddr = fr.addr;
        d.toDefaultWorkReg = !fr.toFile;
        d.destWorkReg = difd_pkg::DEFAULT_WORK_REG;
        d.flagMask = difd_pkg::FLAGS_MCU;
      end
      [difd_pkg::GRP_BIT_LO:difd_pkg::GRP_BIT_HI]: begin
        d.cat = difd_pkg::CAT_BIT;
        d.width = difd_pkg::WID_WORD;
        d.bitIndirect = op[2];
        d.bitSelectField = br.bitSel;
        d.baseWorkReg = br.base;
        d.sourceWorkReg = br.sReg;
        d.srcMode = br.sMode;
        d.toDefaultWorkReg = !op[3];
        d.fileAddr = {op[0], o[11:0]};
        d.flagMask = difd_pkg::FLAGS_ZERO;
      end
      [difd_pkg::GRP_LIT_LO:difd_pkg::GRP_LIT_HI]: begin
        d.cat = difd_pkg::CAT_LIT;
        d.baseWorkReg = lr.base;
        d.flagMask = difd_pkg::FLAGS_MCU;
        if (op[2]) begin
          d.lit = {11'h000, l5.lit};
          d.destWorkReg = l5.dReg;
          d.dstMode = l5.dMode;
        end else begin
          d.lit = {6'h00, lr.lit};
          d.destWorkReg = lr.base;
          d.illegal = op[3] && (lr.lit > difd_pkg::BYTE_LIT_MAX);
        end
      end
      difd_pkg::GRP_MAC: begin
        d.cat = difd_pkg::CAT_DSP;
        d.accB = op[3];
        d.flagMask = difd_pkg::FLAGS_DSP;
        // operand pairs 4*5 4*6 4*7 5*6 5*7 6*7
        case (op[2:0])
          3'h0: {d.mulM, d.mulN} = {difd_pkg::MUL_BASE_REG, difd_pkg::MUL_BASE_REG + 4'h1};
          3'h1: {d.mulM, d.mulN} = {difd_pkg::MUL_BASE_REG, difd_pkg::MUL_BASE_REG + 4'h2};
          3'h2: {d.mulM, d.mulN} = {difd_pkg::MUL_BASE_REG, difd_pkg::MUL_BASE_REG + 4'h3};
          3'h3: {d.mulM, d.mulN} = {difd_pkg::MUL_BASE_REG + 4'h1, difd_pkg::MUL_BASE_REG + 4'h2};
          3'h4: {d.mulM, d.mulN} = {difd_pkg::MUL_BASE_REG + 4'h1, difd_pkg::MUL_BASE_REG + 4'h3};
          3'h5: {d.mulM, d.mulN} = {difd_pkg::MUL_BASE_REG + 4'h2, difd_pkg::MUL_BASE_REG + 4'h3};
          default: d.illegal = 1'b1;
        endcase
        // X prefetch: seven codes per register, then offset, then none
        k = (mr.xPf < difd_pkg::XPF_GROUP) ? mr.xPf : mr.xPf - difd_pkg::XPF_GROUP;
        d.xPfEn = (mr.xPf != difd_pkg::XPF_CODE_NONE);
        d.xPfOfs = (mr.xPf == difd_pkg::XPF_CODE_OFS);
        d.xPrefetchAddrReg = (mr.xPf < difd_pkg::XPF_GROUP) ? difd_pkg::XPF_REG_LO
                                                            : difd_pkg::XPF_REG_HI;
        case (k)
          4'h0: d.xPfStep = 4'h6;
          4'h1: d.xPfStep = 4'h4;
          4'h2: d.xPfStep = 4'h2;
          4'h4: d.xPfStep = 4'hA;
          4'h5: d.xPfStep = 4'hC;
          4'h6: d.xPfStep = 4'hE;
          default: d.xPfStep = 4'h0;
        endcase
        if (!d.xPfEn || d.xPfOfs) begin
          d.xPfStep = 4'h0;
        end
        d.xDst = mr.xDst;
        d.yPf = mr.yPf;
        d.yDst = mr.yDst;
        d.awbEn = (mr.acc_writeback_target == difd_pkg::AWB_CODE_REG) || (mr.acc_writeback_target == difd_pkg::AWB_CODE_INC);
        d.awbPostInc = (mr.acc_writeback_target == difd_pkg::AWB_CODE_INC);
        d.destWorkReg = d.awbEn ? difd_pkg::AWB_REG : 4'h0;
        if (mr.acc_writeback_target == 2'h3) begin
          d.illegal = 1'b1;
        end
      end
      difd_pkg::GRP_DSP: begin
        d.cat = difd_pkg::CAT_DSP;
        d.accB = op[3];
        d.shiftFromReg = op[2];
        d.shiftCountReg = dr.shLit[3:0];
        d.lit = {{10{dr.shLit[5]}}, dr.shLit};
        d.flagMask = difd_pkg::FLAGS_DSP;
        if (dr.toDst) begin
          d.destWorkReg = dr.reg4;
          d.dstMode = dr.mode;
        end else begin
          d.sourceWorkReg = dr.reg4;
          d.srcMode = dr.mode;
        end
      end
      difd_pkg::GRP_CTRL: begin
        d.width = difd_pkg::WID_WORD;
        d.lit = o;
        d.fileAddr = o[12:0];
        d.baseWorkReg = o[3:0];
        d.twoWord = twoWordOp(op);
        if (d.twoWord) begin
          d.programAddrLiteral = {w2[6:0], o};
          d.illegal = (w2[23:16] != 8'h00) || o[0];
        end
        if (op > difd_pkg::OPC_BRANCH_COND || op == 8'h03) begin
          d.illegal = 1'b1;
        end
      end
      default: d.illegal = 1'b1;
    endcase
    decode = d;
  endfunction

  // handshake toward the fetch path
  assign opNow = fetchWord[23:16];
  assign take = fetchValid && fetchReady;
  assign extra = extraCycles(opNow, condTrue);
  assign fetchReady = ctrlReg[difd_pkg::CTRL_EN_BIT] && (stateReg != S_WAIT);

  // sequencer next state and decode outputs
  always_comb begin
    stateNext = stateReg;
    firstNext = firstReg;
    waitNext = waitReg;
    waitNopNext = waitNopReg;
    decNext = decReg;
    decValidNext = 1'b0;
    wrEnNext = 1'b0;
    nopNext = 1'b0;
    issue = 1'b0;
    dIssue = decode(fetchWord, 24'h0);
    unique case (stateReg)
      S_RUN: begin
        if (take) begin
          if (twoWordOp(opNow)) begin
            firstNext = fetchWord;
            stateNext = S_WORD2;
          end else begin
            issue = 1'b1;
            if (opNow == difd_pkg::OPC_SKIP && condTrue) begin
              stateNext = S_SKIP1;
            end else if (extra != 2'h0) begin
              waitNext = extra;
              waitNopNext = (opNow[7:4] != difd_pkg::GRP_DMOVE);
              stateNext = S_WAIT;
            end
          end
        end
      end
      S_WORD2: begin
        if (take) begin
          dIssue = decode(firstReg, fetchWord);
          issue = 1'b1;
          stateNext = S_RUN;
        end
      end
      S_WAIT: begin
        nopNext = waitNopReg;
        waitNext = waitReg - 2'h1;
        if (waitReg == 2'h1) begin
          stateNext = S_RUN;
        end
      end
      S_SKIP1: begin
        if (take) begin
          nopNext = 1'b1;
          stateNext = twoWordOp(opNow) ? S_SKIP2 : S_RUN;
        end
      end
      S_SKIP2: begin
        if (take) begin
          nopNext = 1'b1;
          stateNext = S_RUN;
        end
      end
    endcase
    if (issue) begin
      decNext = dIssue;
      decValidNext = 1'b1;
      nopNext = (dIssue.opc == difd_pkg::OPC_NOP);
      wrEnNext = !dIssue.illegal && (dIssue.opc != difd_pkg::OPC_NOP);
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stateReg <= S_RUN;
      firstReg <= 24'h0;
      waitReg <= 2'h0;
      waitNopReg <= 1'b0;
      decReg <= '0;
      decValidReg <= 1'b0;
      wrEnReg <= 1'b0;
      nopReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      firstReg <= firstNext;
      waitReg <= waitNext;
      waitNopReg <= waitNopNext;
      decReg <= decNext;
      decValidReg <= decValidNext;
      wrEnReg <= wrEnNext;
      nopReg <= nopNext;
    end
  end

  assign decValid = decValidReg;
  assign decOut = decReg;
  assign writeEnable = wrEnReg;
  assign nopCycle = nopReg;

  // register port next values; a new illegal op wins over its clear
  always_comb begin
    ctrlNext = ctrlReg;
    illNext = illReg;
    countNext = countReg;
    rdataNext = 16'h0000;
    if (regWr && regAddr == difd_pkg::REG_CTRL) begin
      ctrlNext = {15'h0000, regWdata[difd_pkg::CTRL_EN_BIT]};
    end
    if (regWr && regAddr == difd_pkg::REG_STATUS && regWdata[difd_pkg::STAT_ILL_BIT]) begin
      illNext = 1'b0;
    end
    if (issue && dIssue.illegal) begin
      illNext = 1'b1;
    end
    if (issue) begin
      countNext = countReg + 16'h0001;
    end
    if (regRd) begin
      case (regAddr)
        difd_pkg::REG_CTRL: rdataNext = ctrlReg;
        difd_pkg::REG_STATUS: rdataNext = {14'h0000, stateReg != S_RUN, illReg};
        difd_pkg::REG_COUNT: rdataNext = countReg;
        difd_pkg::REG_LAST: rdataNext = {5'h00, decReg.cat, decReg.opc};
        default: rdataNext = 16'h0000;
      endcase
    end
  end

  // register port flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrlReg <= difd_pkg::CTRL_RST;
      illReg <= 1'b0;
      countReg <= 16'h0000;
      rdataReg <= 16'h0000;
    end else begin
      ctrlReg <= ctrlNext;
      illReg <= illNext;
      countReg <= countNext;
      rdataReg <= rdataNext;
    end
  end

  assign regRdata = rdataReg;

endmodule // difd_decoder
`default_nettype wire

// ===== verif/difd_decoder_asserts.sv
`default_nettype none
module difd_decoder_asserts (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                nrst,
  // fetch path
  input wire logic                fetchValid,
  input wire logic [23:0]         fetchWord,
  input wire logic                fetchReady,
  input wire logic                condTrue,
  // decode result
  input wire logic                decValid,
  input wire difd_pkg::difd_dec_s decOut,
  input wire logic                writeEnable,
  input wire logic                nopCycle,
  // register port
  input wire logic [3:0]          regAddr,
  input wire logic [15:0]         regWdata,
  input wire logic                regWr,
  input wire logic                regRd,
  input wire logic [15:0]         regRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // inserted nop cycles after a flow change, fetch held off in the cycle before each one
  sequence nop_tail;
    nopCycle && !fetchReady ##1 nopCycle;
  endsequence
  sequence one_nop;
    !fetchReady ##1 nopCycle;
  endsequence
  dec_after_take_a: assert property (decValid |-> $past(fetchValid && fetchReady))
    else $error("decode without a taken word");
  return_wait_a: assert property (decValid && decOut.opc == difd_pkg::OPC_RETURN
    |-> !fetchReady ##1 nop_tail) else $error("return cycle count wrong");
  cond_nop_a: assert property (decValid && decOut.opc == difd_pkg::OPC_BRANCH_COND
    && $past(condTrue) |-> one_nop) else $error("true branch lacks nop cycle");
  nop_no_write_a: assert property (nopCycle |-> !writeEnable)
    else $error("write during nop cycle");
  illegal_no_write_a: assert property (decValid && decOut.illegal |-> !writeEnable)
    else $error("write from illegal opcode");
  byte_lit_a: assert property (decValid && decOut.cat == difd_pkg::CAT_LIT
    && decOut.width == difd_pkg::WID_BYTE && !decOut.illegal |-> decOut.lit <= 16'h00FF)
    else $error("byte literal above 255");
  prog_addr_a: assert property (decValid && decOut.twoWord && !decOut.illegal
    |-> !decOut.programAddrLiteral[0]) else $error("odd program address accepted");
  xpf_reg_a: assert property (decValid && decOut.opc[7:4] == difd_pkg::GRP_MAC
    && decOut.xPfEn && !decOut.xPfOfs && !decOut.illegal
    |-> decOut.xPrefetchAddrReg inside {4'h8, 4'h9}) else $error("bad prefetch register");
endmodule // difd_decoder_asserts
bind difd_decoder difd_decoder_asserts i_asserts (.clk_sys(clk_sys), .nrst(nrst),
  .fetchValid(fetchValid), .fetchWord(fetchWord), .fetchReady(fetchReady),
  .condTrue(condTrue), .decValid(decValid), .decOut(decOut), .writeEnable(writeEnable),
  .nopCycle(nopCycle), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata));
`default_nettype wire

// ===== verif/difd_fetch_model.sv
`default_nettype none
module difd_fetch_model (
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         nrst,
  // pacing and handshake
  input wire logic         slow,
  input wire logic         fetchReady,
  output logic             fetchValid,
  output logic [23:0]      fetchWord,
  output logic             condTrue
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [24:0] pend[$];
  int          seed = 71;
  logic        take;
  initial begin
    fetchValid = 1'b0;
    fetchWord = 24'h00_0000;
    condTrue = 1'b0;
  end
  // words go out whole and in order, held until taken; idle lines keep toggling
  always @(posedge clk_sys) begin
    take = nrst && fetchValid && fetchReady;
    if (take) void'(pend.pop_front());
    if (fetchValid && !take) begin
      fetchValid <= 1'b1;
    end else if (pend.size() > 0 && (!slow || ($random(seed) & 1) == 1)) begin
      fetchValid <= 1'b1;
      fetchWord <= pend[0][23:0];
      condTrue <= pend[0][24];
    end else begin
      fetchValid <= 1'b0;
      fetchWord <= ~fetchWord;
      condTrue <= ~condTrue;
    end
  end
endmodule // difd_fetch_model
`default_nettype wire

// ===== verif/difd_instruction_format_decoder_tb.sv
`default_nettype none
module difd_instruction_format_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] opc; logic ill; logic chk; logic [2:0] cat; logic [1:0] wid;
    logic two; logic [22:0] addr; logic [12:0] fa; logic dflt;
  } difd_exp_s;
  logic                clk_sys, nrst, slow, fetchValid, fetchReady, condTrue;
  logic                decValid, writeEnable, nopCycle, regWr, regRd, skipPend;
  logic [23:0]         fetchWord;
  logic [3:0]          regAddr;
  logic [15:0]         regWdata, regRdata;
  difd_pkg::difd_dec_s decOut;
  difd_exp_s           expQ[$];
  difd_exp_s           ex, lastExp;
  logic [7:0]          ctl [11] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09,
                                    8'h0A, 8'h0B, 8'h0D, 8'h0E};
  int                  n_fail = 0;
  int                  check_count = 0;
  int                  seed = 71;
  int                  nNop = 0;
  difd_decoder i_dut (.clk_sys(clk_sys), .nrst(nrst), .fetchValid(fetchValid),
    .fetchWord(fetchWord), .fetchReady(fetchReady), .condTrue(condTrue), .decValid(decValid),
    .decOut(decOut), .writeEnable(writeEnable), .nopCycle(nopCycle), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  difd_fetch_model i_fetch (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
    .fetchReady(fetchReady), .fetchValid(fetchValid), .fetchWord(fetchWord),
    .condTrue(condTrue));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys); // strobe low one cycle so two writes never clash in one step
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 check(regRdata, exp);
    @(posedge clk_sys);
  endtask
  // reference decode of one instruction, queued unless a taken skip swallows it
  task automatic issue(input logic c, input logic [23:0] w, input logic [23:0] w2);
    difd_exp_s e;
    logic [3:0] g;
    g = w[23:20];
    e = '0;
    e.opc = w[23:16];
    e.chk = g < 4'hC;
    e.two = e.opc inside {difd_pkg::OPC_CALL_LONG, difd_pkg::OPC_GOTO_LONG,
                          difd_pkg::OPC_LOOP_LONG};
    e.addr = {w2[6:0], w[15:0]};
    e.fa = w[12:0];
    e.dflt = !w[13];
    e.ill = (g == 4'h0 && (e.opc == 8'h03 || e.opc > 8'h0D)) || g == 4'hF
      || (e.two && (w2[23:16] != 8'h00 || w[0]))
      || (g inside {4'hA, 4'hB} && w[19] && w[15:6] > 10'h0FF);
    e.cat = g == 4'h0 ? difd_pkg::CAT_CTRL : g < 4'h8 ? difd_pkg::CAT_WORD
      : g < 4'hA ? difd_pkg::CAT_BIT : difd_pkg::CAT_LIT;
    e.wid = (g != 4'h0 && w[19]) ? difd_pkg::WID_BYTE : difd_pkg::WID_WORD;
    i_fetch.pend.push_back({c, w});
    if (e.two) i_fetch.pend.push_back({1'b0, w2});
    if (skipPend) skipPend = 1'b0;
    else begin
      expQ.push_back(e);
      skipPend = c && e.opc == difd_pkg::OPC_SKIP;
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 400 && (expQ.size() > 0 || i_fetch.pend.size() > 0); i++)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check(expQ.size(), 0);
  endtask
  // compare every decode with the reference queue
  always @(posedge clk_sys) begin
    if (nrst === 1'b1 && decValid === 1'b1) begin
      if (expQ.size() == 0) check(32'h1, 32'h0);
      else begin
        ex = expQ.pop_front();
        lastExp = ex;
        check(decOut.opc, ex.opc);
        if (ex.chk) begin
          check(decOut.illegal, ex.ill);
          check(writeEnable, !ex.ill && ex.opc != 8'h00);
          if (!ex.ill) check(3'(decOut.cat), ex.cat);
          if (!ex.ill) check(2'(decOut.width), ex.wid);
          if (ex.two && !ex.ill) check(decOut.programAddrLiteral, ex.addr);
          if (!ex.ill && ex.opc[7:5] == 3'b011) check(decOut.fileAddr, ex.fa);
          if (!ex.ill && ex.opc[7:5] == 3'b011) check(decOut.toDefaultWorkReg, ex.dflt);
        end
      end
    end
  end
  // count inserted nop cycles for the cycle budget checks
  always @(posedge clk_sys) if (nrst === 1'b1 && nopCycle === 1'b1) nNop++;
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    slow = 1'b0;
    skipPend = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    reg_rd(difd_pkg::REG_CTRL, difd_pkg::CTRL_RST);
    reg_rd(difd_pkg::REG_STATUS, 16'h0000);
    reg_wr(difd_pkg::REG_COUNT, 16'hFFFF);
    reg_wr(4'h9, 16'hFFFF);
    reg_rd(difd_pkg::REG_COUNT, 16'h0000);
    reg_rd(4'h9, 16'h0000);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      issue(1'b0, 24'h10_0000, 24'h00_0000);
      issue(1'b0, 24'h18_0000, 24'h00_0000);
      issue(1'b0, {8'h60, 3'b000, 13'($random(seed))}, 24'h00_0000);
      issue(1'b0, 24'h68_3FFF, 24'h00_0000);
      issue(1'b0, 24'h80_F000, 24'h00_0000);
      issue(1'b0, {8'hA8, 10'h0FF, 6'h01}, 24'h00_0000);
      issue(1'b0, {8'hA8, 10'h100, 6'h01}, 24'h00_0000);
      issue(1'b0, {8'hA0, 10'h3FF, 6'h01}, 24'h00_0000);
      foreach (ctl[i]) issue(ctl[i] == difd_pkg::OPC_BRANCH_COND, {ctl[i], 16'h0000},
                             24'h00_0000);
      issue(1'b0, 24'h04_1234, 24'h00_0056);
      issue(1'b0, 24'h02_0010, 24'h01_0000);
      issue(1'b0, 24'h05_0011, 24'h00_0000);
      issue(1'b1, 24'h0C_0000, 24'h00_0000);
      issue(1'b0, 24'h18_0000, 24'h00_0000);
      issue(1'b1, 24'h0C_0000, 24'h00_0000);
      issue(1'b0, 24'h04_0100, 24'h00_0001);
      issue(1'b0, 24'hC0_0000, 24'h00_0000);
      issue(1'b0, 24'hD0_0000, 24'h00_0000);
      issue(1'b0, 24'hE0_0000, 24'h00_0000);
      issue(1'b0, 24'hF0_0000, 24'h00_0000);
      issue(1'b0, 24'h0C_0000, 24'h00_0000);
      issue(1'b0, 24'h10_0000, 24'h00_0000);
      drain();
      // per stream: nop 1, two returns 2 each, five flow ops and true branch 1 each, skips 1+2
      check(nNop, 14 * (p + 1));
      $display("test stream %0d done", p);
    end
    reg_rd(difd_pkg::REG_LAST, {5'b00000, lastExp.cat, lastExp.opc});
    reg_rd(difd_pkg::REG_STATUS, 16'h0001);
    reg_wr(difd_pkg::REG_STATUS, 16'h0001);
    reg_rd(difd_pkg::REG_STATUS, 16'h0000);
    reg_wr(difd_pkg::REG_CTRL, 16'h0000);
    issue(1'b0, 24'h10_0000, 24'h00_0000);
    repeat (4) @(posedge clk_sys);
    check(fetchReady, 1'b0);
    check(expQ.size(), 1);
    reg_wr(difd_pkg::REG_CTRL, 16'h0001);
    drain();
    $display("test disable done");
    finish_test();
  end
endmodule // difd_instruction_format_decoder_tb
`default_nettype wire
